// ===== hdl/etsc_edge.sv
// Slope and level crossing detector with hysteresis for one analog source
`timescale 1ns/1ps
`default_nettype none
`include "etsc_map.svh"
module etsc_edge #(
	parameter int W = `ETSC_SMP_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Sample and thresholds
	input  wire logic [W-1:0] smp,
	input  wire logic [W-1:0] lvl,
	input  wire logic [W-1:0] hyst,
	// Crossing pulses
	output logic              rise,
	output logic              fall
);
	typedef struct packed {
		logic arm_r;
		logic arm_f;
		logic rise;
		logic fall;
	} etsc_edge_t;

	etsc_edge_t s_r;
	etsc_edge_t s_nxt;
	logic       below_band;
	logic       above_band;

	// Slope is armed only after leaving the noise band on the far side
	assign below_band = ({1'b0, smp} + {1'b0, hyst}) < {1'b0, lvl};
	assign above_band = {1'b0, smp} > ({1'b0, lvl} + {1'b0, hyst});

	always_comb begin
		s_nxt = s_r;
		s_nxt.rise = s_r.arm_r && (smp >= lvl);
		s_nxt.fall = s_r.arm_f && (smp < lvl);
		if (s_nxt.rise) begin
			s_nxt.arm_r = 1'b0;
		end else if (below_band) begin
			s_nxt.arm_r = 1'b1;
		end
		if (s_nxt.fall) begin
			s_nxt.arm_f = 1'b0;
		end else if (above_band) begin
			s_nxt.arm_f = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rise = s_r.rise;
	assign fall = s_r.fall;

	AST_RISE_AT_LEVEL: assert property (@(posedge clk) disable iff (rst)
		(s_r.arm_r && smp >= lvl) |=> (rise && !s_r.arm_r))
		else $error("armed rising crossing gave no pulse");
	AST_NO_RISE_UNARMED: assert property (@(posedge clk) disable iff (rst)
		(!s_r.arm_r && !below_band) |=> !s_r.arm_r ##1 !rise)
		else $error("rising pulse without hysteresis arming");
endmodule
`default_nettype wire

// ===== hdl/etsc_map.svh
// Register offsets, field positions, reset values and counts of the edge trigger block
`ifndef ETSC_MAP_SVH
`define ETSC_MAP_SVH

`define ETSC_SMP_W        12
`define ETSC_NSRC         5
`define ETSC_CNT_W        24
`define ETSC_ADDR_W       8

`define ETSC_OFF_CTRL     8'h20
`define ETSC_OFF_SRC      8'h04
`define ETSC_OFF_SLOPE    8'h08
`define ETSC_OFF_COUP     8'h0C
`define ETSC_OFF_HOLD     8'h10
`define ETSC_OFF_TMO      8'h14
`define ETSC_OFF_HYST     8'h18
`define ETSC_OFF_STAT     8'h1C
`define ETSC_OFF_LVL0     8'h40
`define ETSC_OFF_LVL4     8'h50

`define ETSC_CTRL_SWEEP   1:0
`define ETSC_CTRL_MODE    6:4
`define ETSC_CTRL_ARM     8

`define ETSC_MODE_EDGE    3'h0
`define ETSC_MODE_RST     3'h0
`define ETSC_LVL_RST      12'h800
`define ETSC_HYST_RST     12'h010
`define ETSC_HOLD_RST     24'h00_0010
`define ETSC_AUTO_TIME_US 10000
`define ETSC_CLK_MHZ      100
`define ETSC_TMO_RST      (`ETSC_AUTO_TIME_US * `ETSC_CLK_MHZ)

`endif

// ===== hdl/etsc_pkg.sv
// Types shared by the edge trigger block
`include "etsc_map.svh"
package etsc_pkg;
	typedef enum logic [1:0] {
		ETSC_AUTO   = 2'h0,
		ETSC_TRIGD  = 2'h1,
		ETSC_SINGLE = 2'h2
	} etsc_sweep_t;
	typedef enum logic [1:0] {
		ETSC_POS    = 2'h0,
		ETSC_NEG    = 2'h1,
		ETSC_EITHER = 2'h2
	} etsc_slope_t;
	typedef enum logic [2:0] {
		ETSC_CH1  = 3'h0,
		ETSC_CH2  = 3'h1,
		ETSC_CH3  = 3'h2,
		ETSC_CH4  = 3'h3,
		ETSC_AUX  = 3'h4,
		ETSC_LINE = 3'h5
	} etsc_src_t;
	typedef enum logic [2:0] {
		ETSC_ST_STOP  = 3'b001,
		ETSC_ST_ARMED = 3'b010,
		ETSC_ST_HOLD  = 3'b100
	} etsc_state_t;
	typedef struct packed {
		etsc_state_t                                st;
		etsc_sweep_t                                sweep;
		logic [2:0]                                 mode;
		etsc_src_t                                  src;
		etsc_slope_t [`ETSC_NSRC-1:0]               slope;
		logic [1:0]                                 coup;
		logic [`ETSC_SMP_W-1:0]                     hyst;
		logic [`ETSC_NSRC-1:0][`ETSC_SMP_W-1:0]     lvl;
		logic [`ETSC_CNT_W-1:0]                     hold;
		logic [`ETSC_CNT_W-1:0]                     tmo;
		logic [`ETSC_CNT_W-1:0]                     auto_cnt;
		logic [`ETSC_CNT_W-1:0]                     hold_cnt;
		logic                                       arm_req;
		logic                                       start;
		logic                                       forced;
		logic                                       last_forced;
		logic                                       line_q;
		logic                                       pready;
		logic                                       pslverr;
		logic [31:0]                                prdata;
	} etsc_st_t;
endpackage

// ===== hdl/etsc_top.sv
// Edge trigger qualification and sweep policy controller with APB registers
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The sweep policy holds exactly one of automatic, triggered or single.
// - In automatic policy a missing trigger within the timeout forces a sweep start.
// - In triggered policy no sweep starts without a trigger, so the old record stays.
// - In single policy no sweep starts without a trigger, so the old record stays.
// - An edge trigger needs the chosen slope first, then fires at the level crossing.
// - The edge source is channel 1 to 4, the auxiliary input or the power line.
// - Each source keeps its own slope and the power line has none.
// - There is one level register per input, shared by all trigger modes.
// - A level written in any trigger mode changes the same level edge mode uses.
// - The power line source is used without any level comparison.
// - Holdoff, hysteresis and coupling condition the edge before qualification.
// - The slope may also be either, so both crossings qualify.
`include "etsc_map.svh"
module etsc_top (
	// Clock and reset
	input  wire logic                                CLOCK,
	input  wire logic                                RST,
	// APB slave
	input  wire logic                                PSEL,
	input  wire logic                                PENABLE,
	input  wire logic                                PWRITE,
	input  wire logic [`ETSC_ADDR_W-1:0]             PADDR,
	input  wire logic [31:0]                         PWDATA,
	output logic                                     PREADY,
	output logic [31:0]                              PRDATA,
	output logic                                     PSLVERR,
	// Trigger sources
	input  wire logic [4*`ETSC_SMP_W-1:0]            CH_SAMPLE,
	input  wire logic [`ETSC_SMP_W-1:0]              AUX_SAMPLE,
	input  wire logic                                LINE_REF,
	// Sweep engine and front end
	output logic                                     SWEEP_START,
	output logic                                     SWEEP_FORCED,
	output logic                                     SWEEP_ARMED,
	output logic [1:0]                               COUPLING
);
	localparam int W = `ETSC_SMP_W;
	localparam int NS = `ETSC_NSRC;

	etsc_pkg::etsc_st_t        s_r;
	etsc_pkg::etsc_st_t        s_nxt;
	logic [NS-1:0][W-1:0]      smp;
	logic [NS-1:0]             rise;
	logic [NS-1:0]             fall;
	logic                      line_rise;
	logic                      ev;
	logic                      wr;
	logic                      lvl_hit;
	logic [2:0]                lvl_idx;
	logic                      edge_mode;

	// Source inputs and per-source crossing detectors
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_src
			if (g < 4) begin : g_ch
				assign smp[g] = CH_SAMPLE[g*W +: W];
			end else begin : g_aux
				assign smp[g] = AUX_SAMPLE;
			end
			etsc_edge #(
				.W (W)
			) u_edge (
				.clk  (CLOCK),
				.rst  (RST),
				.smp  (smp[g]),
				.lvl  (s_r.lvl[g]),
				.hyst (s_r.hyst),
				.rise (rise[g]),
				.fall (fall[g])
			);
		end
	endgenerate

	// Power line takes its rising edge directly
	assign line_rise = LINE_REF && !s_r.line_q;

	always_comb begin
		ev = 1'b0;
		if (s_r.src == etsc_pkg::ETSC_LINE) begin
			ev = line_rise;
		end else if (s_r.src <= etsc_pkg::ETSC_AUX) begin
			case (s_r.slope[s_r.src])
				etsc_pkg::ETSC_POS: ev = rise[s_r.src];
				etsc_pkg::ETSC_NEG: ev = fall[s_r.src];
				etsc_pkg::ETSC_EITHER: ev = rise[s_r.src] || fall[s_r.src];
				default: ev = 1'b0;
			endcase
		end
	end

	assign wr = PSEL && PENABLE && PWRITE && s_r.pready;
	assign edge_mode = (s_r.mode == `ETSC_MODE_EDGE);
	// Level block is aligned so the word index is the low address bits
	assign lvl_hit = (PADDR >= `ETSC_OFF_LVL0) && (PADDR <= `ETSC_OFF_LVL4) && (PADDR[1:0] == 2'h0);
	assign lvl_idx = PADDR[4:2];

	always_comb begin
		logic [31:0] rd;
		logic        hit;
		rd = 32'h0000_0000;
		hit = 1'b1;
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.forced = 1'b0;
		s_nxt.line_q = LINE_REF;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0000_0000;

		// Sweep sequencer
		case (s_r.st)
			etsc_pkg::ETSC_ST_STOP: begin
				if (s_r.sweep != etsc_pkg::ETSC_SINGLE || s_r.arm_req) begin
					s_nxt.st = etsc_pkg::ETSC_ST_ARMED;
					s_nxt.arm_req = 1'b0;
					s_nxt.auto_cnt = '0;
				end
			end
			etsc_pkg::ETSC_ST_ARMED: begin
				s_nxt.auto_cnt = s_r.auto_cnt + 1'b1;
				// Arm request is used up once armed, so it cannot re-arm a later single
				s_nxt.arm_req = 1'b0;
				if (ev) begin
					s_nxt.start = 1'b1;
					s_nxt.last_forced = 1'b0;
					s_nxt.st = etsc_pkg::ETSC_ST_HOLD;
					s_nxt.hold_cnt = s_r.hold;
					s_nxt.auto_cnt = '0;
				end else if (s_r.sweep == etsc_pkg::ETSC_AUTO && s_r.auto_cnt >= s_r.tmo) begin
					s_nxt.start = 1'b1;
					s_nxt.forced = 1'b1;
					s_nxt.last_forced = 1'b1;
					s_nxt.st = etsc_pkg::ETSC_ST_HOLD;
					s_nxt.hold_cnt = s_r.hold;
					s_nxt.auto_cnt = '0;
				end
			end
			etsc_pkg::ETSC_ST_HOLD: begin
				if (s_r.hold_cnt == '0) begin
					s_nxt.auto_cnt = '0;
					if (s_r.sweep == etsc_pkg::ETSC_SINGLE) begin
						s_nxt.st = etsc_pkg::ETSC_ST_STOP;
					end else begin
						s_nxt.st = etsc_pkg::ETSC_ST_ARMED;
					end
				end else begin
					s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.st = etsc_pkg::ETSC_ST_STOP;
			end
		endcase

		// Read mux and decode
		case (PADDR)
			`ETSC_OFF_CTRL: begin
				rd[`ETSC_CTRL_SWEEP] = s_r.sweep;
				rd[`ETSC_CTRL_MODE] = s_r.mode;
				rd[`ETSC_CTRL_ARM] = s_r.arm_req;
			end
			`ETSC_OFF_SRC: rd[2:0] = s_r.src;
			`ETSC_OFF_SLOPE: begin
				if (s_r.src <= etsc_pkg::ETSC_AUX) begin
					rd[1:0] = s_r.slope[s_r.src];
				end
			end
			`ETSC_OFF_COUP: rd[1:0] = s_r.coup;
			`ETSC_OFF_HOLD: rd[`ETSC_CNT_W-1:0] = s_r.hold;
			`ETSC_OFF_TMO: rd[`ETSC_CNT_W-1:0] = s_r.tmo;
			`ETSC_OFF_HYST: rd[W-1:0] = s_r.hyst;
			`ETSC_OFF_STAT: begin
				rd[2:0] = s_r.st;
				rd[3] = s_r.last_forced;
			end
			default: begin
				if (lvl_hit) begin
					rd[W-1:0] = s_r.lvl[lvl_idx];
				end else begin
					hit = 1'b0;
				end
			end
		endcase

		// APB setup phase prepares a zero-wait answer
		if (PSEL && !PENABLE) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = !hit;
			if (!PWRITE) begin
				s_nxt.prdata = rd;
			end
		end

		// Register writes, after the sequencer so an arm request is never lost
		if (wr) begin
			case (PADDR)
				`ETSC_OFF_CTRL: begin
					if (PWDATA[`ETSC_CTRL_SWEEP] <= etsc_pkg::ETSC_SINGLE) begin
						s_nxt.sweep = etsc_pkg::etsc_sweep_t'(PWDATA[`ETSC_CTRL_SWEEP]);
					end
					s_nxt.mode = PWDATA[`ETSC_CTRL_MODE];
					if (PWDATA[`ETSC_CTRL_ARM]) begin
						s_nxt.arm_req = 1'b1;
					end
				end
				`ETSC_OFF_SRC: begin
					if (edge_mode && PWDATA[2:0] <= etsc_pkg::ETSC_LINE) begin
						s_nxt.src = etsc_pkg::etsc_src_t'(PWDATA[2:0]);
					end
				end
				`ETSC_OFF_SLOPE: begin
					if (edge_mode && s_r.src != etsc_pkg::ETSC_LINE
						&& PWDATA[1:0] <= etsc_pkg::ETSC_EITHER) begin
						s_nxt.slope[s_r.src] = etsc_pkg::etsc_slope_t'(PWDATA[1:0]);
					end
				end
				`ETSC_OFF_COUP: begin
					if (edge_mode && s_r.src != etsc_pkg::ETSC_LINE) begin
						s_nxt.coup = PWDATA[1:0];
					end
				end
				`ETSC_OFF_HOLD: s_nxt.hold = PWDATA[`ETSC_CNT_W-1:0];
				`ETSC_OFF_TMO: s_nxt.tmo = PWDATA[`ETSC_CNT_W-1:0];
				`ETSC_OFF_HYST: s_nxt.hyst = PWDATA[W-1:0];
				default: begin
					if (lvl_hit) begin
						s_nxt.lvl[lvl_idx] = PWDATA[W-1:0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s_r <= '0;
			s_r.st <= etsc_pkg::ETSC_ST_STOP;
			s_r.sweep <= etsc_pkg::ETSC_AUTO;
			s_r.mode <= `ETSC_MODE_RST;
			s_r.src <= etsc_pkg::ETSC_CH1;
			s_r.hyst <= `ETSC_HYST_RST;
			s_r.lvl <= {NS{`ETSC_LVL_RST}};
			s_r.hold <= `ETSC_HOLD_RST;
			s_r.tmo <= `ETSC_CNT_W'(`ETSC_TMO_RST);
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PREADY = s_r.pready;
	assign PRDATA = s_r.prdata;
	assign PSLVERR = s_r.pslverr;
	assign SWEEP_START = s_r.start;
	assign SWEEP_FORCED = s_r.forced;
	assign SWEEP_ARMED = s_r.st[1];
	assign COUPLING = s_r.coup;

	AST_SWEEP_LEGAL: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_CTRL) |=> (s_r.sweep != 2'h3)
		&& (s_r.sweep == $past(PWDATA[1:0]) || $past(PWDATA[1:0]) == 2'h3))
		else $error("sweep policy left its three values");
	AST_AUTO_FORCE: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_ARMED && s_r.sweep == etsc_pkg::ETSC_AUTO
		&& s_r.auto_cnt >= s_r.tmo && !ev) |=> (SWEEP_START && SWEEP_FORCED))
		else $error("automatic timeout did not force a sweep");
	AST_TRIGD_NO_FORCE: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.sweep != etsc_pkg::ETSC_AUTO) |=> !SWEEP_FORCED)
		else $error("forced sweep outside automatic policy");
	AST_START_NEEDS_EVENT: assert property (@(posedge CLOCK) disable iff (RST)
		(SWEEP_START && !SWEEP_FORCED) |-> $past(ev) && $past(s_r.st) == etsc_pkg::ETSC_ST_ARMED)
		else $error("sweep started without a trigger");
	AST_SINGLE_STOPS: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_HOLD && s_r.hold_cnt == '0
		&& s_r.sweep == etsc_pkg::ETSC_SINGLE && !s_r.arm_req && !wr)
		|=> (s_r.st == etsc_pkg::ETSC_ST_STOP) [*2])
		else $error("single policy re-armed by itself");
	AST_SRC_RANGE: assert property (@(posedge CLOCK) disable iff (RST)
		s_r.src <= etsc_pkg::ETSC_LINE)
		else $error("edge source out of range");
	AST_LINE_NO_SLOPE: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_SLOPE && s_r.src == etsc_pkg::ETSC_LINE) |=> $stable(s_r.slope))
		else $error("slope stored for the power line");
	AST_LEVEL_ONE_REG: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && lvl_hit && lvl_idx != 3'h0) |=> $stable(s_r.lvl[0]))
		else $error("level write touched another channel");
	AST_LEVEL_ANY_MODE: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && lvl_hit && lvl_idx == 3'h1) |=> (s_r.lvl[1] == $past(PWDATA[W-1:0])))
		else $error("level write lost in this trigger mode");
	AST_LINE_NO_LEVEL: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.src == etsc_pkg::ETSC_LINE && s_r.st == etsc_pkg::ETSC_ST_ARMED && $rose(LINE_REF))
		|=> (SWEEP_START && !SWEEP_FORCED))
		else $error("power line edge did not start a sweep");
	AST_EDGE_MODE_GATE: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_SRC && !edge_mode) |=> $stable(s_r.src))
		else $error("source changed outside edge mode");
	AST_HOLDOFF_QUIET: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_HOLD && s_r.hold_cnt != '0) |=> !SWEEP_START)
		else $error("sweep started inside holdoff");
	AST_EITHER_EDGE: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_ARMED && s_r.src <= etsc_pkg::ETSC_AUX
		&& s_r.slope[s_r.src] == etsc_pkg::ETSC_EITHER && fall[s_r.src])
		|=> (SWEEP_START && !SWEEP_FORCED))
		else $error("falling crossing ignored with either slope");
	AST_AUTO_RESTART: assert property (@(posedge CLOCK) disable iff (RST)
		SWEEP_START |-> (s_r.auto_cnt == '0))
		else $error("timeout count not restarted by trigger");
	AST_START_PULSE: assert property (@(posedge CLOCK) disable iff (RST)
		SWEEP_START |=> !SWEEP_START)
		else $error("sweep start lasted more than one cycle");
	AST_FORCED_WITH_START: assert property (@(posedge CLOCK) disable iff (RST)
		SWEEP_FORCED |-> SWEEP_START)
		else $error("forced flag without a sweep start");
	AST_TRIGD_WAITS: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_ARMED && s_r.sweep == etsc_pkg::ETSC_TRIGD && !ev)
		|=> !SWEEP_START)
		else $error("triggered policy swept without a trigger");
	AST_TRIGD_REARMS: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_HOLD && s_r.hold_cnt == '0
		&& s_r.sweep != etsc_pkg::ETSC_SINGLE) |=> SWEEP_ARMED)
		else $error("repeating policy did not re-arm after holdoff");
	AST_SINGLE_WAITS: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_ARMED && s_r.sweep == etsc_pkg::ETSC_SINGLE && !ev)
		|=> !SWEEP_START)
		else $error("single policy swept without a trigger");
	AST_SINGLE_ARM: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_STOP && s_r.arm_req) |=> SWEEP_ARMED)
		else $error("arm request did not arm a single sweep");
	AST_SRC_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_SRC && edge_mode && PWDATA[2:0] <= 3'h5)
		|=> (s_r.src == $past(PWDATA[2:0])))
		else $error("legal source write not stored");
	AST_SLOPE_TARGET: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_SLOPE && edge_mode && s_r.src != etsc_pkg::ETSC_LINE
		&& PWDATA[1:0] <= 2'h2) |=> (s_r.slope[s_r.src] == $past(PWDATA[1:0])))
		else $error("slope did not land on the selected source");
	AST_COUP_GATE: assert property (@(posedge CLOCK) disable iff (RST)
		(wr && PADDR == `ETSC_OFF_COUP && (!edge_mode || s_r.src == etsc_pkg::ETSC_LINE))
		|=> $stable(COUPLING))
		else $error("coupling changed by a refused write");
	AST_HOLD_LOAD: assert property (@(posedge CLOCK) disable iff (RST)
		SWEEP_START |-> (s_r.hold_cnt == $past(s_r.hold)))
		else $error("holdoff not loaded at sweep start");
	AST_AUTO_WAITS: assert property (@(posedge CLOCK) disable iff (RST)
		(s_r.st == etsc_pkg::ETSC_ST_ARMED && !ev && s_r.auto_cnt < s_r.tmo)
		|=> !SWEEP_START)
		else $error("forced sweep before the timeout count");
endmodule
`default_nettype wire

// ===== verif/etsc_sweep_eng.sv
// Sweep engine stand-in that counts acquired records
`timescale 1ns/1ps
`default_nettype none
module etsc_sweep_eng (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Sweep requests
	input  wire logic start,
	input  wire logic forced,
	// Record counters
	output var int    records,
	output var int    forced_cnt
);
	// A record is replaced only when a sweep starts
	always @(posedge clk) begin
		if (rst) begin
			records    <= 0;
			forced_cnt <= 0;
		end else if (start) begin
			records    <= records + 1;
			forced_cnt <= forced_cnt + (forced ? 1 : 0);
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the edge trigger block
`timescale 1ns/1ps
`default_nettype none
`include "etsc_map.svh"
module tb;
	logic        clk, rst, psel, penable, pwrite, line_ref, pready, pslverr;
	logic        st, fo, armed, er, f;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [47:0] ch;
	logic [11:0] aux;
	logic [1:0]  coup;
	int          failures, samples_checked, records, forced_cnt, r0, n, h;
	int          m_mode, m_sweep, m_src, m_coup, m_hold, m_tmo, m_hyst;
	int          m_slope[6];
	int          m_lvl[5];

	etsc_top DUT (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
		.CH_SAMPLE(ch), .AUX_SAMPLE(aux), .LINE_REF(line_ref), .SWEEP_START(st),
		.SWEEP_FORCED(fo), .SWEEP_ARMED(armed), .COUPLING(coup));
	etsc_sweep_eng ENG (.clk(clk), .rst(rst), .start(st), .forced(fo), .records(records),
		.forced_cnt(forced_cnt));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for ready with a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) failures++;
	endtask

	function automatic logic [31:0] mrd(input logic [7:0] a);
		case (a)
		`ETSC_OFF_CTRL:  return 32'(m_mode * 16 + m_sweep);
		`ETSC_OFF_SRC:   return 32'(m_src);
		`ETSC_OFF_SLOPE: return (m_src == 5) ? 32'h0 : 32'(m_slope[m_src]);
		`ETSC_OFF_COUP:  return 32'(m_coup);
		`ETSC_OFF_HOLD:  return 32'(m_hold);
		`ETSC_OFF_TMO:   return 32'(m_tmo);
		`ETSC_OFF_HYST:  return 32'(m_hyst);
		default:         return 32'(m_lvl[(a - 8'h40) / 4]);
		endcase
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk_b(er, 1'b0);
		case (a)
		`ETSC_OFF_CTRL: begin
			if (d[1:0] != 2'h3) m_sweep = d[1:0];
			m_mode = d[6:4];
		end
		`ETSC_OFF_SRC:   if (m_mode == 0 && d[2:0] <= 5) m_src = d[2:0];
		`ETSC_OFF_SLOPE: if (m_mode == 0 && m_src != 5 && d[1:0] <= 2) m_slope[m_src] = d[1:0];
		`ETSC_OFF_COUP:  if (m_mode == 0 && m_src != 5) m_coup = d[1:0];
		`ETSC_OFF_HOLD:  m_hold = d[23:0];
		`ETSC_OFF_TMO:   m_tmo = d[23:0];
		`ETSC_OFF_HYST:  m_hyst = d[11:0];
		default:         m_lvl[(a - 8'h40) / 4] = d[11:0];
		endcase
	endtask

	task automatic rdc(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk_w(rd, mrd(a));
	endtask

	task automatic drv(input int c, input int v);
		@(posedge clk);
		if (c < 4) ch[c*12 +: 12] <= 12'(v);
		else aux <= 12'(v);
	endtask

	task automatic watch(input int cyc);
		h = 0;
		repeat (cyc) begin
			@(negedge clk);
			if (st === 1'b1) begin
				h++;
				f = fo;
			end
		end
	endtask

	task automatic gap();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (st !== 1'b1 && n < 500);
		f = fo;
		if (n >= 500) failures++;
	endtask

	// Approach from the far side, then cross the level in the chosen direction
	task automatic xing(input int c, input bit up, input bit exp);
		drv(c, up ? m_lvl[c] - 256 : m_lvl[c] + 256);
		watch(12);
		chk_b(h == 0, 1'b1);
		drv(c, up ? m_lvl[c] + 256 : m_lvl[c] - 256);
		watch(6);
		chk_b(h == 1, exp);
		if (h > 0) chk_b(f, 1'b0);
	endtask

	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		finish_test();
	end

	initial begin
		logic [7:0] a;
		rst = 1'b1;
		{psel, penable, pwrite, line_ref} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ch = 48'h0;
		aux = 12'h0;
		failures = 0;
		samples_checked = 0;
		{m_mode, m_sweep, m_src, m_coup} = {0, 0, 0, 0};
		{m_hold, m_tmo, m_hyst} = {16, 1000000, 16};
		foreach (m_slope[i]) m_slope[i] = 0;
		foreach (m_lvl[i]) m_lvl[i] = 12'h800;
		void'($urandom(32'ha8b1));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 12; i++) begin
			a = (i < 7) ? 8'(i * 4) : 8'(8'h40 + (i - 7) * 4);
			rdc((i == 0) ? `ETSC_OFF_CTRL : a);
		end
		apb(1'b0, `ETSC_OFF_STAT, 32'h0);
		chk_w(rd, 32'h2);
		apb(1'b0, 8'h30, 32'h0);
		chk_b(er, 1'b1);
		chk_w(rd, 32'h0);
		wr(`ETSC_OFF_CTRL, 32'h3);
		rdc(`ETSC_OFF_CTRL);
		wr(`ETSC_OFF_CTRL, 32'h1);
		wr(`ETSC_OFF_TMO, 32'd20);
		wr(`ETSC_OFF_HOLD, 32'h4);
		rdc(`ETSC_OFF_TMO);
		for (int c = 0; c < 5; c++) wr(8'(8'h40 + c * 4), 32'd512 + $urandom_range(0, 2047));
		for (int c = 0; c < 5; c++) rdc(8'(8'h40 + c * 4));
		for (int c = 0; c < 5; c++) begin
			for (int s = 0; s < 3; s++) begin
				wr(`ETSC_OFF_SRC, c);
				wr(`ETSC_OFF_SLOPE, s);
				rdc(`ETSC_OFF_SLOPE);
				xing(c, 1'b1, s != 1);
				xing(c, 1'b0, s != 0);
			end
		end
		for (int c = 0; c < 5; c++) begin
			wr(`ETSC_OFF_SRC, c);
			wr(`ETSC_OFF_SLOPE, c % 3);
		end
		for (int c = 0; c < 5; c++) begin
			wr(`ETSC_OFF_SRC, c);
			rdc(`ETSC_OFF_SLOPE);
		end
		wr(`ETSC_OFF_COUP, 32'h3);
		@(negedge clk);
		chk_w(32'(coup), 32'h3);
		wr(`ETSC_OFF_SRC, 32'h5);
		wr(`ETSC_OFF_SLOPE, 32'h1);
		wr(`ETSC_OFF_COUP, 32'h1);
		rdc(`ETSC_OFF_SLOPE);
		chk_w(32'(coup), 32'h3);
		@(posedge clk);
		line_ref <= 1'b1;
		watch(6);
		chk_b(h == 1, 1'b1);
		@(posedge clk);
		line_ref <= 1'b0;
		watch(6);
		chk_b(h == 0, 1'b1);
		wr(`ETSC_OFF_SRC, 32'h0);
		drv(0, m_lvl[0] + 256);
		watch(12);
		r0 = records;
		drv(0, m_lvl[0] - 8);
		watch(6);
		drv(0, m_lvl[0] + 256);
		watch(100);
		chk_b(h == 0, 1'b1);
		chk_w(32'(records), 32'(r0));
		wr(`ETSC_OFF_CTRL, 32'h11);
		wr(`ETSC_OFF_LVL0 + 8'h4, 32'd512 + $urandom_range(0, 2047));
		wr(`ETSC_OFF_SRC, 32'h3);
		rdc(`ETSC_OFF_LVL0 + 8'h4);
		rdc(`ETSC_OFF_SRC);
		wr(`ETSC_OFF_CTRL, 32'h1);
		wr(`ETSC_OFF_SRC, 32'h1);
		xing(1, 1'b0, 1'b1);
		wr(`ETSC_OFF_SRC, 32'h0);
		wr(`ETSC_OFF_CTRL, 32'h0000_0102);
		xing(0, 1'b1, 1'b1);
		repeat (8) @(negedge clk);
		apb(1'b0, `ETSC_OFF_STAT, 32'h0);
		chk_w(rd, 32'h1);
		chk_b(armed, 1'b0);
		r0 = records;
		xing(0, 1'b1, 1'b0);
		chk_w(32'(records), 32'(r0));
		wr(`ETSC_OFF_CTRL, 32'h0000_0102);
		xing(0, 1'b1, 1'b1);
		wr(`ETSC_OFF_CTRL, 32'h0000_0100);
		gap();
		chk_b(f, 1'b1);
		drv(0, m_lvl[0] - 256);
		repeat (14) @(negedge clk);
		drv(0, m_lvl[0] + 256);
		gap();
		chk_b(f, 1'b0);
		gap();
		chk_b(f, 1'b1);
		chk_b(n == m_tmo + m_hold + 2, 1'b1);
		@(negedge clk);
		chk_w(32'(forced_cnt), 32'h2);
		finish_test();
	end
endmodule
`default_nettype wire
